// [shared/ccftg_pkg.sv]
// Constants, register map and reset values of the frame timing generator
// How it works
// - Each line sends end code, horizontal blanking, start code, then active samples.
// - A timing code is 0xFF, 0x00, 0x00, then the code byte.
// - Code byte carries four protection bits computed from field, vertical, horizontal bits.
// - Field 1 codes: 80/9D outside vertical blanking, AB/B6 during it.
// - Field 2 codes: C7/DA outside vertical blanking, EC/F1 during it.
// - Timing codes are inserted whether timing is generated or followed.
// - With clipping on, samples are held within programmable minimum and maximum.
// - Frame lines are numbered from 1 up to 525 or 625.
// - 525-line default geometry gives the standard field and vertical flags.
// - 625-line geometry is reached by programming the same fields.
// - Progressive output is two identical fields; no dedicated mode.
// - Frame line counter starts at one and counts to the frame length.
// - Field 2 region holds while line is at or past field-two start.
// - Active video when line and pixel reach their video start settings.
// - Overlaps are signed four-bit values, -8 to +7 lines.
// - In an overlap vertical blanking is new while field flag stays old.
// - First overlap acts at field 2 blanking start, second at field 1.
// - Frame counters start at line 1 pixel 1 and reload when master.
// - Following outside timing, the line counter does not wrap until an external edge.
// - Image starts at video start plus vertical and horizontal image offsets.
// - Image counters start at zero, stop at size, reset at image start.
// - Outside the image blanking bytes 0x80, 0x10, 0x80, 0x10 are sent.
// - Bit 6 of the code byte is the field flag.
// - Output bytes change on rising edges of the video clock.
// - A pixel pair is four bytes: U, Y0, V, Y1.
// - With sync master set the block makes its own frame timing.
`default_nettype none
package ccftg_pkg;
    // Register byte offsets
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_FRAME = 8'h04;
    localparam logic [7:0] OFF_FIELD = 8'h08;
    localparam logic [7:0] OFF_LINE = 8'h0C;
    localparam logic [7:0] OFF_IMG_OFF = 8'h10;
    localparam logic [7:0] OFF_IMG_SIZE = 8'h14;
    localparam logic [7:0] OFF_CLIP = 8'h18;
    localparam logic [7:0] OFF_STATUS = 8'h1C;
    // Field positions
    localparam int CTRL_ENABLE = 0;
    localparam int CTRL_MASTER = 1;
    localparam int CTRL_CLIP = 2;
    localparam int CTRL_POS = 3;
    localparam int LO_POS = 0;
    localparam int HI_POS = 16;
    localparam int OLAP1_POS = 12;
    localparam int OLAP2_POS = 28;
    localparam int CMAX_POS = 8;
    localparam int ST_F_POS = 30;
    localparam int ST_V_POS = 29;
    // Reset values, 525-line geometry
    localparam logic [10:0] RST_FRAME_LEN = 11'h20D;
    localparam logic [10:0] RST_F2_START = 11'h108;
    localparam logic [10:0] RST_F1_VLINE = 11'h014;
    localparam logic [10:0] RST_F2_VLINE = 11'h11B;
    localparam logic [3:0] RST_FIRST_FIELD_OVERLAP = 4'h2;
    localparam logic [3:0] RST_SECOND_FIELD_OVERLAP = 4'h3;
    localparam logic [11:0] RST_LINE_LEN = 12'h35A;
    localparam logic [11:0] RST_VPIX = 12'h08A;
    localparam logic [10:0] RST_IMG_H = 11'h0F4;
    localparam logic [11:0] RST_IMG_W = 12'h2D0;
    localparam logic [7:0] RST_CMIN = 8'h01;
    localparam logic [7:0] RST_CMAX = 8'hFE;
    // Stream bytes
    localparam logic [7:0] PRE_ONES = 8'hFF;
    localparam logic [7:0] PRE_ZERO = 8'h00;
    localparam logic [7:0] BLANK_C = 8'h80;
    localparam logic [7:0] BLANK_Y = 8'h10;
    localparam logic [11:0] CODE_PIX = 12'h001;
    localparam logic [11:0] SAV_LEAD = 12'h002;
endpackage
`default_nettype wire

// [shared/ccftg_code_if.sv]
// Carrier between the timing core and the code and clip unit
`timescale 1ns/1ps
`default_nettype none
interface ccftg_code_if;
    logic field;
    logic vblank;
    logic eav;
    logic clip_en;
    logic [7:0] cmin;
    logic [7:0] cmax;
    logic [7:0] sample;
    logic [7:0] code;
    logic [7:0] clipped;
    modport gen (output field, vblank, eav, clip_en, cmin, cmax, sample,
                 input code, clipped);
    modport coder (input field, vblank, eav, clip_en, cmin, cmax, sample,
                   output code, clipped);
endinterface
`default_nettype wire

// [hw/ccftg_sync.sv]
// Two-flop synchroniser with edge detection per input bit
`timescale 1ns/1ps
`default_nettype none
module ccftg_sync #(parameter int WIDTH = 2) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Asynchronous inputs and results
    input wire logic [WIDTH-1:0] din,
    output logic [WIDTH-1:0] rise,
    output logic [WIDTH-1:0] fall
);
    for (genvar i = 0; i < WIDTH; i++) begin : g_bit
        logic meta, stable, prev;
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                meta <= 1'b0;
                stable <= 1'b0;
                prev <= 1'b0;
            end else begin
                meta <= din[i];
                stable <= meta;
                prev <= stable;
            end
        end
        assign rise[i] = stable & ~prev;
        assign fall[i] = ~stable & prev;
    end
endmodule // ccftg_sync
`default_nettype wire

// [hw/ccftg_code.sv]
// Timing code byte builder and sample clipper
`timescale 1ns/1ps
`default_nettype none
module ccftg_code (
    // Flags in, code and clipped sample out
    ccftg_code_if.coder cif
);
    logic f, v, h;
    always_comb begin
        f = cif.field;
        v = cif.vblank;
        h = cif.eav;
        // Protection bits over F, V, H
        cif.code = {1'b1, f, v, h, v ^ h, f ^ h, f ^ v, f ^ v ^ h};
    end
    always_comb begin
        cif.clipped = cif.sample;
        if (cif.clip_en) begin
            if (cif.sample < cif.cmin) begin
                cif.clipped = cif.cmin;
            end else if (cif.sample > cif.cmax) begin
                cif.clipped = cif.cmax;
            end
        end
    end
endmodule // ccftg_code
`default_nettype wire

// [hw/ccftg_frame_timing_gen.sv]
// Frame timing generator: counters, flags, code insertion and APB registers
`timescale 1ns/1ps
`default_nettype none
module ccftg_frame_timing_gen (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Video link
    input wire logic video_out_clock,
    input wire logic frame_sync_in,
    output logic [7:0] video_out_bytes,
    // Pixel pair source
    input wire logic [7:0] pixel_u,
    input wire logic [7:0] pixel_y0,
    input wire logic [7:0] pixel_v,
    input wire logic [7:0] pixel_y1,
    output logic pixel_taken
);
    // Registers
    logic enable, sync_master, clip_en, sync_pos;
    logic [10:0] frame_len, f2_start, f1_vline, f2_vline, img_voff, img_h;
    logic [3:0] first_field_overlap, second_field_overlap;
    logic [11:0] line_len, vpix, img_hoff, img_w;
    logic [7:0] cmin, cmax;
    // Counters and state
    logic [10:0] line, img_line;
    logic [11:0] pix, img_pix;
    logic [1:0] phase;
    logic [1:0] rise, fall;
    logic byte_en, ext_edge, pix_adv, line_end;
    logic region2, f_code, v_flag, is_code, is_eav, img_act;
    logic [10:0] img_sline;
    logic [11:0] img_spix, pair_pix, next_pix;
    logic [7:0] next_byte;
    logic signed [12:0] line_s, f1_switch, f2_end, wrap_end;
    logic apb_wr, apb_setup, mapped;
    logic [31:0] rd_mux;

    ccftg_code_if cif ();

    ccftg_sync #(.WIDTH(2)) u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .din({frame_sync_in, video_out_clock}),
        .rise(rise),
        .fall(fall)
    );

    ccftg_code u_code (
        .cif(cif)
    );

    // Bytes move on rising video clock edges only
    assign byte_en = rise[0] & enable;
    assign ext_edge = enable & ~sync_master & (sync_pos ? rise[1] : fall[1]);
    assign pix_adv = byte_en & phase[0];
    assign line_end = pix_adv & (pix == line_len);
    assign next_pix = (pix == line_len) ? 12'h001 : pix + 12'h001;

    // APB decode
    assign apb_setup = psel & ~penable;
    assign apb_wr = psel & penable & pready & pwrite;
    always_comb begin
        mapped = 1'b1;
        rd_mux = 32'h0000_0000;
        unique case (paddr)
            ccftg_pkg::OFF_CTRL: begin
                rd_mux[ccftg_pkg::CTRL_ENABLE] = enable;
                rd_mux[ccftg_pkg::CTRL_MASTER] = sync_master;
                rd_mux[ccftg_pkg::CTRL_CLIP] = clip_en;
                rd_mux[ccftg_pkg::CTRL_POS] = sync_pos;
            end
            ccftg_pkg::OFF_FRAME: begin
                rd_mux[ccftg_pkg::LO_POS +: 11] = frame_len;
                rd_mux[ccftg_pkg::HI_POS +: 11] = f2_start;
            end
            ccftg_pkg::OFF_FIELD: begin
                rd_mux[ccftg_pkg::LO_POS +: 11] = f1_vline;
                rd_mux[ccftg_pkg::OLAP1_POS +: 4] = first_field_overlap;
                rd_mux[ccftg_pkg::HI_POS +: 11] = f2_vline;
                rd_mux[ccftg_pkg::OLAP2_POS +: 4] = second_field_overlap;
            end
            ccftg_pkg::OFF_LINE: begin
                rd_mux[ccftg_pkg::LO_POS +: 12] = line_len;
                rd_mux[ccftg_pkg::HI_POS +: 12] = vpix;
            end
            ccftg_pkg::OFF_IMG_OFF: begin
                rd_mux[ccftg_pkg::LO_POS +: 11] = img_voff;
                rd_mux[ccftg_pkg::HI_POS +: 12] = img_hoff;
            end
            ccftg_pkg::OFF_IMG_SIZE: begin
                rd_mux[ccftg_pkg::LO_POS +: 11] = img_h;
                rd_mux[ccftg_pkg::HI_POS +: 12] = img_w;
            end
            ccftg_pkg::OFF_CLIP: begin
                rd_mux[ccftg_pkg::LO_POS +: 8] = cmin;
                rd_mux[ccftg_pkg::CMAX_POS +: 8] = cmax;
            end
            ccftg_pkg::OFF_STATUS: begin
                rd_mux[ccftg_pkg::LO_POS +: 11] = line;
                rd_mux[ccftg_pkg::HI_POS +: 12] = pix;
                rd_mux[ccftg_pkg::ST_V_POS] = v_flag;
                rd_mux[ccftg_pkg::ST_F_POS] = f_code;
            end
            default: mapped = 1'b0;
        endcase
    end

    // No wait state: answer in the first access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            pready <= apb_setup;
            pslverr <= apb_setup & ~mapped;
            prdata <= (apb_setup & ~pwrite) ? rd_mux : 32'h0000_0000;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            enable <= 1'b0;
            sync_master <= 1'b1;
            clip_en <= 1'b0;
            sync_pos <= 1'b1;
            frame_len <= ccftg_pkg::RST_FRAME_LEN;
            f2_start <= ccftg_pkg::RST_F2_START;
            f1_vline <= ccftg_pkg::RST_F1_VLINE;
            f2_vline <= ccftg_pkg::RST_F2_VLINE;
            first_field_overlap <= ccftg_pkg::RST_FIRST_FIELD_OVERLAP;
            second_field_overlap <= ccftg_pkg::RST_SECOND_FIELD_OVERLAP;
            line_len <= ccftg_pkg::RST_LINE_LEN;
            vpix <= ccftg_pkg::RST_VPIX;
            img_voff <= 11'h000;
            img_hoff <= 12'h000;
            img_h <= ccftg_pkg::RST_IMG_H;
            img_w <= ccftg_pkg::RST_IMG_W;
            cmin <= ccftg_pkg::RST_CMIN;
            cmax <= ccftg_pkg::RST_CMAX;
        end else if (apb_wr) begin
            unique case (paddr)
                ccftg_pkg::OFF_CTRL: begin
                    enable <= pwdata[ccftg_pkg::CTRL_ENABLE];
                    sync_master <= pwdata[ccftg_pkg::CTRL_MASTER];
                    clip_en <= pwdata[ccftg_pkg::CTRL_CLIP];
                    sync_pos <= pwdata[ccftg_pkg::CTRL_POS];
                end
                ccftg_pkg::OFF_FRAME: begin
                    frame_len <= pwdata[ccftg_pkg::LO_POS +: 11];
                    f2_start <= pwdata[ccftg_pkg::HI_POS +: 11];
                end
                ccftg_pkg::OFF_FIELD: begin
                    f1_vline <= pwdata[ccftg_pkg::LO_POS +: 11];
                    first_field_overlap <= pwdata[ccftg_pkg::OLAP1_POS +: 4];
                    f2_vline <= pwdata[ccftg_pkg::HI_POS +: 11];
                    second_field_overlap <= pwdata[ccftg_pkg::OLAP2_POS +: 4];
                end
                ccftg_pkg::OFF_LINE: begin
                    line_len <= pwdata[ccftg_pkg::LO_POS +: 12];
                    vpix <= pwdata[ccftg_pkg::HI_POS +: 12];
                end
                ccftg_pkg::OFF_IMG_OFF: begin
                    img_voff <= pwdata[ccftg_pkg::LO_POS +: 11];
                    img_hoff <= pwdata[ccftg_pkg::HI_POS +: 12];
                end
                ccftg_pkg::OFF_IMG_SIZE: begin
                    img_h <= pwdata[ccftg_pkg::LO_POS +: 11];
                    img_w <= pwdata[ccftg_pkg::HI_POS +: 12];
                end
                ccftg_pkg::OFF_CLIP: begin
                    cmin <= pwdata[ccftg_pkg::LO_POS +: 8];
                    cmax <= pwdata[ccftg_pkg::CMAX_POS +: 8];
                end
                default: ;
            endcase
        end
    end

    // Field and vertical flags; progressive is just two equal fields
    always_comb begin
        line_s = $signed({2'b00, line});
        f1_switch = $signed({2'b00, f2_start}) + $signed({{9{first_field_overlap[3]}}, first_field_overlap});
        f2_end = 13'sh0001 + $signed({{9{second_field_overlap[3]}}, second_field_overlap});
        wrap_end = $signed({2'b00, frame_len}) + f2_end;
        region2 = line >= f2_start;
        // Field flag lags the field region by the overlaps
        // Negative overlap only moves blanking earlier; flag switches at field start
        f_code = first_field_overlap[3] ? (line >= f2_start) : (line_s >= f1_switch);
        if (!second_field_overlap[3] && line_s < f2_end) begin
            f_code = 1'b1;
        end
        // Vertical blanking of the new field starts early on negative overlap
        v_flag = region2 ? (line < f2_vline) : (line < f1_vline);
        if (first_field_overlap[3] && !region2 && line_s >= f1_switch) begin
            v_flag = 1'b1;
        end
        if (second_field_overlap[3] && line_s >= wrap_end) begin
            v_flag = 1'b1;
        end
    end

    // Pair position, code slots and image area
    always_comb begin
        pair_pix = phase[1] ? pix - 12'h001 : pix;
        is_eav = pair_pix == ccftg_pkg::CODE_PIX;
        // Codes go in whichever timing source is active
        is_code = is_eav || (pair_pix == vpix - ccftg_pkg::SAV_LEAD);
        img_sline = (region2 ? f2_vline : f1_vline) + img_voff;
        img_spix = vpix + img_hoff;
        img_act = !is_code && !v_flag && line >= img_sline && img_line < img_h
                  && pix >= img_spix && img_pix < img_w;
    end

    assign cif.field = f_code;
    assign cif.vblank = v_flag;
    assign cif.eav = is_eav;
    assign cif.clip_en = clip_en;
    assign cif.cmin = cmin;
    assign cif.cmax = cmax;

    // Byte selection
    always_comb begin
        unique case (phase)
            2'b00: cif.sample = pixel_u;
            2'b01: cif.sample = pixel_y0;
            2'b10: cif.sample = pixel_v;
            2'b11: cif.sample = pixel_y1;
        endcase
        if (is_code) begin
            unique case (phase)
                2'b00: next_byte = ccftg_pkg::PRE_ONES;
                2'b01: next_byte = ccftg_pkg::PRE_ZERO;
                2'b10: next_byte = ccftg_pkg::PRE_ZERO;
                2'b11: next_byte = cif.code;
            endcase
        end else if (img_act) begin
            next_byte = cif.clipped;
        end else begin
            next_byte = phase[0] ? ccftg_pkg::BLANK_Y : ccftg_pkg::BLANK_C;
        end
    end

    // Frame counters
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            line <= 11'h001;
            pix <= 12'h001;
            phase <= 2'b00;
        end else if (!enable || ext_edge) begin
            line <= 11'h001;
            pix <= 12'h001;
            phase <= 2'b00;
        end else if (byte_en) begin
            phase <= phase + 2'b01;
            if (pix_adv) begin
                pix <= next_pix;
            end
            if (line_end) begin
                if (line == frame_len && sync_master) begin
                    line <= 11'h001;
                end else if (line != 11'h7FF) begin
                    line <= line + 11'h001;
                end
            end
        end
    end

    // Image counters
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            img_line <= 11'h000;
            img_pix <= 12'h000;
        end else if (pix_adv) begin
            if (next_pix == img_spix) begin
                img_pix <= 12'h000;
            end else if (pix >= img_spix && img_pix < img_w) begin
                img_pix <= img_pix + 12'h001;
            end
            if (line_end) begin
                if (line + 11'h001 == img_sline) begin
                    img_line <= 11'h000;
                end else if (line >= img_sline && img_line < img_h) begin
                    img_line <= img_line + 11'h001;
                end
            end
        end
    end

    // Output stream
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            video_out_bytes <= 8'h00;
            pixel_taken <= 1'b0;
        end else begin
            pixel_taken <= byte_en & img_act & (phase == 2'b11);
            if (byte_en) begin
                video_out_bytes <= next_byte;
            end
        end
    end

    // Checks
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_code_byte;
        byte_en && is_code && phase == 2'b11;
    endsequence

    property p_apb_answer;
        @(posedge pclk) disable iff (!presetn)
        s_setup |=> pready ##1 !pready;
    endproperty
    a_apb_answer: assert property (p_apb_answer) else $error("apb answer late");

    property p_preamble;
        @(posedge pclk) disable iff (!presetn)
        byte_en && is_code && phase != 2'b11 |=>
            video_out_bytes == (($past(phase) == 2'b00) ? 8'hFF : 8'h00);
    endproperty
    a_preamble: assert property (p_preamble) else $error("bad preamble byte");

    property p_protect;
        @(posedge pclk) disable iff (!presetn)
        s_code_byte |=> video_out_bytes[7] && video_out_bytes[3] ==
            (video_out_bytes[5] ^ video_out_bytes[4]) && video_out_bytes[0] ==
            (video_out_bytes[6] ^ video_out_bytes[5] ^ video_out_bytes[4]);
    endproperty
    a_protect: assert property (p_protect) else $error("bad protection bits");

    property p_field_bit;
        @(posedge pclk) disable iff (!presetn)
        s_code_byte |=> video_out_bytes[6] == $past(f_code)
            && video_out_bytes[5] == $past(v_flag);
    endproperty
    a_field_bit: assert property (p_field_bit) else $error("field bit wrong");

    property p_blank;
        @(posedge pclk) disable iff (!presetn)
        byte_en && !is_code && !img_act |=>
            video_out_bytes == ($past(phase[0]) ? 8'h10 : 8'h80);
    endproperty
    a_blank: assert property (p_blank) else $error("bad blanking byte");

    property p_clip;
        @(posedge pclk) disable iff (!presetn)
        byte_en && img_act && clip_en |=>
            video_out_bytes >= $past(cmin) && video_out_bytes <= $past(cmax);
    endproperty
    a_clip: assert property (p_clip) else $error("sample not clipped");

    property p_line_wrap;
        @(posedge pclk) disable iff (!presetn)
        line_end && line == frame_len && sync_master && !ext_edge |=> line == 11'h001;
    endproperty
    a_line_wrap: assert property (p_line_wrap) else $error("line did not wrap");

    property p_no_wrap;
        @(posedge pclk) disable iff (!presetn)
        enable && line_end && line == frame_len && !sync_master && !ext_edge
            && line != 11'h7FF |=> line == $past(line) + 11'h001;
    endproperty
    a_no_wrap: assert property (p_no_wrap) else $error("slave wrapped alone");

    property p_ext_reset;
        @(posedge pclk) disable iff (!presetn)
        ext_edge |=> line == 11'h001 && pix == 12'h001 && phase == 2'b00;
    endproperty
    a_ext_reset: assert property (p_ext_reset) else $error("no external reset");

    property p_line_nonzero;
        @(posedge pclk) disable iff (!presetn)
        line != 11'h000 && pix != 12'h000;
    endproperty
    a_line_nonzero: assert property (p_line_nonzero) else $error("counter at zero");

    property p_img_start;
        @(posedge pclk) disable iff (!presetn)
        pix_adv && next_pix == img_spix |=> img_pix == 12'h000;
    endproperty
    a_img_start: assert property (p_img_start) else $error("image pixel not reset");
endmodule // ccftg_frame_timing_gen
`default_nettype wire

// [bench/ccftg_link_model.sv]
// Link partner: video clock source and output byte sampler
`timescale 1ns/1ps
`default_nettype none
module ccftg_link_model (
    // System clock
    input wire logic pclk,
    // Link
    output logic video_out_clock,
    output logic frame_sync_in,
    input wire logic [7:0] video_out_bytes,
    // Captured stream
    output logic [7:0] rx_byte,
    output logic rx_tick
);
    initial begin
        video_out_clock = 1'b0;
        frame_sync_in = 1'b0;
        rx_byte = 8'h00;
        rx_tick = 1'b0;
        #3;
        forever #40 video_out_clock = ~video_out_clock;
    end
    // Sample well after the byte has settled, before the next rise
    always @(posedge video_out_clock) begin
        repeat (6) @(negedge pclk);
        rx_byte = video_out_bytes;
        rx_tick = ~rx_tick;
    end
endmodule // ccftg_link_model
`default_nettype wire

// [bench/ccftg_frame_timing_gen_bench.sv]
// Testbench for the frame timing generator
`timescale 1ns/1ps
`default_nettype none
module ccftg_frame_timing_gen_bench;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, vclk, fsync, taken, rx_tick;
    logic [7:0] paddr, vbytes, rx_byte;
    logic [31:0] pwdata, prdata, rd;
    logic err;
    int mismatches, compares, taken_n;
    logic [7:0] codes [8] = '{8'h9D, 8'h80, 8'hB6, 8'hAB, 8'hDA, 8'hC7, 8'hF1, 8'hEC};
    logic [7:0] img [4] = '{8'h40, 8'hF0, 8'hC0, 8'h10};
    ccftg_frame_timing_gen dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .video_out_clock(vclk), .frame_sync_in(fsync),
        .video_out_bytes(vbytes), .pixel_u(8'h40), .pixel_y0(8'hFF), .pixel_v(8'hC0),
        .pixel_y1(8'h00), .pixel_taken(taken));
    ccftg_link_model link (.pclk(pclk), .video_out_clock(vclk), .frame_sync_in(fsync),
        .video_out_bytes(vbytes), .rx_byte(rx_byte), .rx_tick(rx_tick));
    always @(negedge pclk) begin
        if (taken === 1'b1) taken_n++;
    end
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1) mismatches++;
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic get_byte(output logic [7:0] b);
        @(rx_tick);
        b = rx_byte;
    endtask
    task automatic summarize();
        $display("Comparisons %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic test_regs();
        apb(1'b0, 8'h00, 32'h0);
        chk("ctrl reset", rd, 32'h0000000A);
        apb(1'b0, 8'h04, 32'h0);
        chk("frame reset", rd, 32'h0108020D);
        apb(1'b0, 8'h20, 32'h0);
        chk("unmapped error", {31'h0, err}, 32'h1);
        chk("unmapped data", rd, 32'h0);
        $display("test_regs done");
    endtask
    task automatic test_stream();
        logic [7:0] b;
        logic [23:0] h;
        logic f, v;
        int l;
        apb(1'b1, 8'h04, 32'h0006000A);
        apb(1'b1, 8'h08, 32'h00080003);
        apb(1'b1, 8'h0C, 32'h0007000A);
        apb(1'b1, 8'h18, 32'h0000F010);
        apb(1'b1, 8'h00, 32'h0000000F);
        h = 24'h0;
        for (int i = 0; i < 400 && h !== 24'hFF0000; i++) begin
            get_byte(b);
            h = {h[15:0], b};
        end
        chk("first preamble", {8'h0, h}, 32'hFF0000);
        for (int ln = 0; ln < 20; ln++) begin
            l = ln % 10 + 1;
            f = l >= 6;
            v = f ? l < 8 : l < 3;
            for (int i = 0; i < 3 && ln > 0; i++) begin
                get_byte(b);
                chk("eav preamble", b, i == 0 ? 8'hFF : 8'h00);
            end
            get_byte(b);
            chk("eav code", b, codes[{f, v, 1'b0}]);
            for (int i = 0; i < 4; i++) begin
                get_byte(b);
                chk("blanking", b, i % 2 ? 8'h10 : 8'h80);
            end
            for (int i = 0; i < 3; i++) begin
                get_byte(b);
                chk("sav preamble", b, i == 0 ? 8'hFF : 8'h00);
            end
            get_byte(b);
            chk("sav code", b, codes[{f, v, 1'b1}]);
            for (int i = 0; i < 8; i++) begin
                get_byte(b);
                chk("active", b, v ? (i % 2 ? 8'h10 : 8'h80) : img[i % 4]);
            end
        end
        chk("pixel taken count", taken_n, 32'h18);
        $display("test_stream done");
    endtask
    task automatic test_genlock();
        logic [7:0] b;
        apb(1'b1, 8'h00, 32'h0000000D);
        for (int i = 0; i < 240; i++) begin
            get_byte(b);
        end
        apb(1'b0, 8'h1C, 32'h0);
        chk("line past length", {31'h0, rd[10:0] > 11'h00A}, 32'h1);
        $display("test_genlock done");
    endtask
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    initial begin
        #100us;
        mismatches++;
        summarize();
    end
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        test_regs();
        test_stream();
        test_genlock();
        summarize();
    end
endmodule // ccftg_frame_timing_gen_bench
`default_nettype wire
